// File: hcp_device.sv
// decoder end: parallel and serial control port, master reset gating, video flags
`include "hcp_consts.svh"
`timescale 1ns/100ps
module hcp_device #(
  parameter logic [3:0] SERIAL_ID_HI = 4'h5, // arbitrary upper id bits
  parameter int         REG_AW       = `HCP_REG_AW,
  parameter int         LUT_AW       = `HCP_LUT_AW
) (
  hcp_if.dev        port,
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic master_rst_n,
  input  wire logic interface_select,
  input  wire logic [2:0] serial_id_straps,
  input  wire logic video_active_in,
  input  wire logic [2:0] drs_field,
  input  wire logic drs_field_valid,
  output logic      active_video_flag,
  output logic [2:0] field_number_out,
  output logic      outputs_enabled
);

  initial begin
    if (REG_AW < 1 || REG_AW > 8 || LUT_AW < 1 || LUT_AW > 8) begin
      $error("hcp_device: address widths must be 1..8");
    end
  end

  // ---------------- link domain ----------------
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic       scl_d;
  logic       sda_d;
  logic       lce;
  logic       mrst_l;
  logic       par_on;

  // pins from other domains pass two flops
  always_ff @(posedge port.link_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= `HCP_SYNC_RESET;
      sync2 <= `HCP_SYNC_RESET;
    end else begin
      sync1 <= {serial_id_straps, port.sda, port.scl, interface_select, master_rst_n, ce};
      sync2 <= sync1;
    end
  end

  assign lce    = sync2[0];
  assign mrst_l = sync2[1];
  assign par_on = sync2[2];

  always_ff @(posedge port.link_clk or negedge rstn) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (lce) begin
      scl_d <= sync2[3];
      sda_d <= sync2[4];
    end
  end

  wire scl_rise = sync2[3] & ~scl_d;
  wire scl_fall = ~sync2[3] & scl_d;
  wire start_ev = scl_d & sync2[3] & sda_d & ~sync2[4];
  wire stop_ev  = scl_d & sync2[3] & ~sda_d & sync2[4];

  // ---------------- parallel port ----------------
  logic cs_q;
  always_ff @(posedge port.link_clk or negedge rstn) begin
    if (!rstn) begin
      cs_q <= 1'b1;
    end else if (lce) begin
      cs_q <= port.cs_n;
    end
  end

  // one write per select cycle, taken on its first link edge
  wire par_first = par_on & ~port.cs_n & cs_q;
  wire par_wr    = par_first & ~port.rw_n;

  // ---------------- storage ----------------
  logic [7:0] regs [2**REG_AW];
  logic [7:0] lut  [2**LUT_AW];
  logic [7:0] reg_ptr;
  logic [7:0] lut_ptr;
  logic       ser_ptr_we;
  logic       ser_dat_we;
  logic [7:0] ser_byte;

  always_ff @(posedge port.link_clk or negedge rstn) begin
    if (!rstn) begin
      reg_ptr <= 8'h00;
      lut_ptr <= 8'h00;
      for (int i = 0; i < 2**REG_AW; i++) begin
        regs[i] <= `HCP_CTRL_RESET;
      end
    end else if (lce) begin
      if (par_wr) begin
        if (port.host_addr_sel == `HCP_SEL_REG_PTR) begin
          reg_ptr <= port.host_data_bus;
        end else if (port.host_addr_sel == `HCP_SEL_REG_DATA) begin
          regs[reg_ptr[REG_AW-1:0]] <= port.host_data_bus;
        end else if (port.host_addr_sel == `HCP_SEL_LUT_PTR) begin
          lut_ptr <= port.host_data_bus;
        end
      end else if (ser_ptr_we) begin
        reg_ptr <= ser_byte;
      end else if (ser_dat_we) begin
        regs[reg_ptr[REG_AW-1:0]] <= ser_byte;
      end
      // master reset beats any host write to the soft bit
      if (!mrst_l) begin
        regs[`HCP_CTRL_REG][`HCP_SOFT_RST_POS] <= 1'b0;
      end
    end
  end

  // table is plain data, left without reset
  always_ff @(posedge port.link_clk) begin
    if (lce && par_wr && port.host_addr_sel == `HCP_SEL_LUT_DATA) begin
      lut[lut_ptr[LUT_AW-1:0]] <= port.host_data_bus;
    end
  end

  logic [7:0] rd_data;
  always_ff @(posedge port.link_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else if (lce) begin
      case (port.host_addr_sel)
        `HCP_SEL_REG_PTR:  rd_data <= reg_ptr;
        `HCP_SEL_REG_DATA: rd_data <= regs[reg_ptr[REG_AW-1:0]];
        `HCP_SEL_LUT_PTR:  rd_data <= lut_ptr;
        default:           rd_data <= lut[lut_ptr[LUT_AW-1:0]];
      endcase
    end
  end

  assign port.dev_o  = rd_data;
  assign port.dev_oe = par_on & ~port.cs_n & port.rw_n;

  // ---------------- serial port ----------------
  hcp_pkg::hcp_ser_state_t sst;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic       rd_mode;
  logic       first_byte;
  logic       sda_drive;
  logic       nack;

  wire ser_on   = ~par_on;
  wire id_match = shreg[7:1] == {SERIAL_ID_HI, sync2[7:5]};

  always_ff @(posedge port.link_clk or negedge rstn) begin
    if (!rstn) begin
      sst        <= hcp_pkg::SER_IDLE;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      txsh       <= 8'h00;
      rd_mode    <= 1'b0;
      first_byte <= 1'b0;
      sda_drive  <= 1'b0;
      nack       <= 1'b0;
      ser_ptr_we <= 1'b0;
      ser_dat_we <= 1'b0;
      ser_byte   <= 8'h00;
    end else if (lce) begin
      ser_ptr_we <= 1'b0;
      ser_dat_we <= 1'b0;
      if (!ser_on || stop_ev) begin
        sst       <= hcp_pkg::SER_IDLE;
        sda_drive <= 1'b0;
      end else if (start_ev) begin
        sst        <= hcp_pkg::SER_ADDR;
        bitcnt     <= 4'h0;
        first_byte <= 1'b1;
        sda_drive  <= 1'b0;
      end else begin
        case (sst)
          hcp_pkg::SER_ADDR, hcp_pkg::SER_WR: begin
            if (scl_rise) begin
              shreg  <= {shreg[6:0], sync2[4]};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (sst == hcp_pkg::SER_ADDR) begin
                if (id_match) begin
                  sda_drive <= 1'b1;
                  rd_mode   <= shreg[0];
                  sst       <= hcp_pkg::SER_ACK;
                end else begin
                  sst <= hcp_pkg::SER_IDLE;
                end
              end else begin
                sda_drive  <= 1'b1;
                ser_byte   <= shreg;
                ser_ptr_we <= first_byte;
                ser_dat_we <= ~first_byte;
                first_byte <= 1'b0;
                sst        <= hcp_pkg::SER_ACK;
              end
            end
          end
          hcp_pkg::SER_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rd_mode) begin
                txsh      <= {regs[reg_ptr[REG_AW-1:0]][6:0], 1'b0};
                sda_drive <= ~regs[reg_ptr[REG_AW-1:0]][7];
                sst       <= hcp_pkg::SER_RD;
              end else begin
                sda_drive <= 1'b0;
                sst       <= hcp_pkg::SER_WR;
              end
            end
          end
          hcp_pkg::SER_RD: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_drive <= 1'b0;
                sst       <= hcp_pkg::SER_RACK;
              end else begin
                sda_drive <= ~txsh[7];
                txsh      <= {txsh[6:0], 1'b0};
              end
            end
          end
          hcp_pkg::SER_RACK: begin
            if (scl_rise) begin
              nack <= sync2[4];
            end else if (scl_fall) begin
              // no auto-increment: a continued read repeats the same register
              bitcnt    <= 4'h0;
              txsh      <= {regs[reg_ptr[REG_AW-1:0]][6:0], 1'b0};
              sda_drive <= ~nack & ~regs[reg_ptr[REG_AW-1:0]][7];
              sst       <= nack ? hcp_pkg::SER_IDLE : hcp_pkg::SER_RD;
            end
          end
          default: begin
            sda_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  assign port.sda_dev_o  = 1'b0;
  assign port.sda_dev_oe = sda_drive;

  // ---------------- video clock domain ----------------
  logic [2:0] csync1;
  logic [2:0] csync2;
  logic       mrst_c_d;
  logic       run;
  logic [2:0] field_hold;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csync1 <= 3'h0;
      csync2 <= 3'h0;
    end else begin
      csync1 <= {regs[`HCP_CTRL_REG][`HCP_SOFT_RST_POS], regs[`HCP_CTRL_REG][`HCP_HARD_RST_POS], master_rst_n};
      csync2 <= csync1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mrst_c_d <= 1'b0;
      run      <= 1'b0;
    end else if (ce) begin
      mrst_c_d <= csync2[0];
      if (!csync2[0]) begin
        run <= 1'b0;
      end else if (!mrst_c_d) begin
        run <= csync2[1];
      end else if (csync2[2]) begin
        run <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      field_hold        <= 3'h0;
      active_video_flag <= 1'b0;
      field_number_out  <= 3'h0;
    end else if (ce) begin
      if (drs_field_valid) begin
        field_hold <= drs_field;
      end
      active_video_flag <= run & video_active_in;
      field_number_out  <= run ? field_hold : 3'h0;
    end
  end

  assign outputs_enabled = run;

endmodule // hcp_device

// File: hcp_consts.svh
// constants for the host control port: offsets, field positions, reset values, timing
`ifndef HCP_CONSTS_SVH
`define HCP_CONSTS_SVH

`define HCP_CTRL_REG        6'h00
`define HCP_SOFT_RST_POS    7
`define HCP_HARD_RST_POS    6
`define HCP_CTRL_RESET      8'h00

`define HCP_SEL_REG_PTR     2'h0
`define HCP_SEL_REG_DATA    2'h1
`define HCP_SEL_LUT_PTR     2'h2
`define HCP_SEL_LUT_DATA    2'h3

`define HCP_REG_AW          6
`define HCP_LUT_AW          8

`define HCP_SYNC_RESET      8'h18

`define HCP_CLK_NS          20
`define HCP_SCL_QUARTER_NS  320
`define HCP_SCL_QUARTER_CYC ((`HCP_SCL_QUARTER_NS + `HCP_CLK_NS - 1) / `HCP_CLK_NS)

`define HCP_PAR_READ_STEPS  2'h2

`endif

// File: hcp_pkg.sv
// types shared by both ends of the host control port
package hcp_pkg;

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_ADDR,
    SER_ACK,
    SER_WR,
    SER_RD,
    SER_RACK
  } hcp_ser_state_t;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_PAR,
    HST_START,
    HST_BIT,
    HST_STOP
  } hcp_host_state_t;

endpackage

// File: hcp_if.sv
// pins between the host controller and the decoder control port
`timescale 1ns/100ps
interface hcp_if;
  logic       link_clk;
  logic       cs_n;
  logic       rw_n;
  logic [1:0] host_addr_sel;
  logic [7:0] host_o;
  logic       host_oe;
  logic [7:0] dev_o;
  logic       dev_oe;
  logic [7:0] host_data_bus;
  logic       scl_o;
  logic       scl_oe;
  logic       scl;
  logic       sda_host_o;
  logic       sda_host_oe;
  logic       sda_dev_o;
  logic       sda_dev_oe;
  logic       sda;

  // undriven parallel bus floats high
  assign host_data_bus = dev_oe ? dev_o : (host_oe ? host_o : 8'hFF);
  assign scl           = (scl_oe & ~scl_o) ? 1'b0 : 1'b1;
  assign sda           = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport dev (
    input  link_clk,
    input  cs_n,
    input  rw_n,
    input  host_addr_sel,
    input  host_data_bus,
    input  scl,
    input  sda,
    output dev_o,
    output dev_oe,
    output sda_dev_o,
    output sda_dev_oe
  );

  modport host (
    output link_clk,
    output cs_n,
    output rw_n,
    output host_addr_sel,
    output host_o,
    output host_oe,
    output scl_o,
    output scl_oe,
    output sda_host_o,
    output sda_host_oe,
    input  host_data_bus,
    input  sda
  );
endinterface

// File: hcp_host.sv
// host end: drives the parallel or serial control port from a command port
`include "hcp_consts.svh"
`timescale 1ns/100ps
module hcp_host #(
  parameter logic [6:0] SERIAL_ID     = 7'h2A, // arbitrary, must match the decoder id
  parameter int         SCL_QTR_CYC   = `HCP_SCL_QUARTER_CYC
) (
  hcp_if.host       port,
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic use_serial,
  input  wire logic cmd_valid,
  output logic      cmd_ready,
  input  wire logic cmd_read,
  input  wire logic [1:0] cmd_sel,
  input  wire logic [7:0] cmd_data,
  output logic      rsp_valid,
  output logic [7:0] rsp_data
);

  initial begin
    if (SCL_QTR_CYC < 4 || SCL_QTR_CYC > 65535) begin
      $error("hcp_host: SCL_QTR_CYC must be 4..65535");
    end
  end

  hcp_pkg::hcp_host_state_t st;
  logic        lclk;
  logic [15:0] qcnt;
  logic [1:0]  ph;
  logic [1:0]  step;
  logic [3:0]  bitn;
  logic [1:0]  nbyte;
  logic [23:0] frame;
  logic [7:0]  rx;
  logic        rd;
  logic [7:0]  host_ptr;

  wire fall = lclk & ce;
  wire tick = ce && qcnt == 16'(SCL_QTR_CYC - 1);
  wire is_rx = rd && nbyte == 2'h1;
  wire take = cmd_valid & cmd_ready;

  assign cmd_ready      = (st == hcp_pkg::HST_IDLE) & ce;
  assign port.link_clk  = lclk;
  assign port.scl_o     = 1'b0;
  assign port.sda_host_o = 1'b0;

  // link clock is clk divided by two and runs free
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lclk <= 1'b0;
      qcnt <= 16'h0000;
    end else if (ce) begin
      lclk <= ~lclk;
      qcnt <= (st == hcp_pkg::HST_IDLE || tick) ? 16'h0000 : qcnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st               <= hcp_pkg::HST_IDLE;
      ph               <= 2'h0;
      step             <= 2'h0;
      bitn             <= 4'h0;
      nbyte            <= 2'h0;
      frame            <= 24'h000000;
      rx               <= 8'h00;
      rd               <= 1'b0;
      host_ptr         <= 8'h00;
      rsp_valid        <= 1'b0;
      rsp_data         <= 8'h00;
      port.cs_n        <= 1'b1;
      port.rw_n        <= 1'b1;
      port.host_addr_sel <= 2'h0;
      port.host_o      <= 8'h00;
      port.host_oe     <= 1'b0;
      port.scl_oe      <= 1'b0;
      port.sda_host_oe <= 1'b0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      case (st)
        hcp_pkg::HST_IDLE: begin
          if (take) begin
            rd   <= cmd_read;
            step <= 2'h0;
            ph   <= 2'h0;
            bitn <= 4'h0;
            if (!cmd_read && cmd_sel == `HCP_SEL_REG_PTR) begin
              host_ptr <= cmd_data;
            end
            if (!use_serial) begin
              st                 <= hcp_pkg::HST_PAR;
              port.host_addr_sel <= cmd_sel;
              port.host_o        <= cmd_data;
            end else begin
              st <= hcp_pkg::HST_START;
              if (cmd_read) begin
                frame <= {SERIAL_ID, 1'b1, 16'h0000};
                nbyte <= 2'h2;
              end else if (cmd_sel[0]) begin
                frame <= {SERIAL_ID, 1'b0, host_ptr, cmd_data};
                nbyte <= 2'h3;
              end else begin
                frame <= {SERIAL_ID, 1'b0, cmd_data, 8'h00};
                nbyte <= 2'h2;
              end
            end
          end
        end
        hcp_pkg::HST_PAR: begin
          if (fall) begin
            step <= step + 2'h1;
            if (step == 2'h0) begin
              port.cs_n    <= 1'b0;
              port.rw_n    <= rd;
              port.host_oe <= ~rd;
            end else if (!rd || step == `HCP_PAR_READ_STEPS) begin
              // release data with the select so rw never rises under drive
              port.cs_n    <= 1'b1;
              port.host_oe <= 1'b0;
              port.rw_n    <= 1'b1;
              rsp_valid    <= rd;
              rsp_data     <= port.host_data_bus;
              st           <= hcp_pkg::HST_IDLE;
            end
          end
        end
        hcp_pkg::HST_START: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              port.sda_host_oe <= 1'b1;
            end else if (ph == 2'h1) begin
              port.scl_oe <= 1'b1;
            end else if (ph == 2'h3) begin
              st <= hcp_pkg::HST_BIT;
            end
          end
        end
        hcp_pkg::HST_BIT: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              port.sda_host_oe <= (bitn < 4'h8) & ~is_rx & ~frame[23];
            end else if (ph == 2'h1) begin
              port.scl_oe <= 1'b0;
            end else if (ph == 2'h2) begin
              if (is_rx && bitn < 4'h8) begin
                rx <= {rx[6:0], port.sda};
              end
            end else begin
              port.scl_oe <= 1'b1;
              if (bitn < 4'h8) begin
                bitn  <= bitn + 4'h1;
                frame <= {frame[22:0], 1'b0};
              end else begin
                bitn  <= 4'h0;
                nbyte <= nbyte - 2'h1;
                if (nbyte == 2'h1) begin
                  st <= hcp_pkg::HST_STOP;
                end
              end
            end
          end
        end
        default: begin
          if (tick) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
              port.sda_host_oe <= 1'b1;
            end else if (ph == 2'h1) begin
              port.scl_oe <= 1'b0;
            end else if (ph == 2'h2) begin
              port.sda_host_oe <= 1'b0;
            end else begin
              rsp_valid <= rd;
              rsp_data  <= rx;
              st        <= hcp_pkg::HST_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule // hcp_host

// File: hcp_checker.sv
// link-side assertions on the parallel and serial control port pins
`timescale 1ns/100ps
module hcp_checker (
  input wire logic       link_clk,
  input wire logic       rstn,
  input wire logic       cs_n,
  input wire logic       rw_n,
  input wire logic [7:0] host_o,
  input wire logic       host_oe,
  input wire logic [7:0] dev_o,
  input wire logic       dev_oe,
  input wire logic [7:0] host_data_bus,
  input wire logic       sda_dev_oe
);
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rstn);

  a_idle_bus_float: assert property (cs_n |-> !dev_oe)
    else $error("decoder drives data while deselected");
  a_write_no_drive: assert property (!cs_n && !rw_n |-> !dev_oe)
    else $error("decoder drives data during a write");
  a_write_data_held: assert property (!cs_n && !rw_n |-> host_oe && host_data_bus == host_o)
    else $error("write cycle without host data on the bus");
  a_drive_only_read: assert property (dev_oe |-> !cs_n && rw_n)
    else $error("decoder drives data outside a read");
  a_read_bus_value: assert property (!cs_n && rw_n && dev_oe |-> host_data_bus == dev_o)
    else $error("read data not on the bus");
  a_no_contention: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the data bus");
  a_release_before_rw: assert property (!cs_n && rw_n |-> !host_oe)
    else $error("host still drives during a read");
  a_access_bounded: assert property ($fell(cs_n) |-> ##[1:2] cs_n)
    else $error("select held too long for one transfer");
  a_one_port_only: assert property (!(dev_oe && sda_dev_oe))
    else $error("both control ports active at once");
endmodule // hcp_checker

// File: host_control_port_and_reset_tb.sv
// bench: host end and decoder end joined across the control port pins
`include "hcp_consts.svh"
`timescale 1ns/100ps
module host_control_port_and_reset_tb;
  logic        clk;
  logic        ce;
  logic        rstn;
  logic        master_rst_n;
  logic        interface_select;
  logic [2:0]  serial_id_straps;
  logic        video_active_in;
  logic [2:0]  drs_field;
  logic        drs_field_valid;
  logic        active_video_flag;
  logic [2:0]  field_number_out;
  logic        outputs_enabled;
  logic        use_serial;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_read;
  logic [1:0]  cmd_sel;
  logic [7:0]  cmd_data;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic [7:0]  regs [64];
  logic [7:0]  lut [256];
  logic [7:0]  q;
  logic [7:0]  a;
  logic [7:0]  t;
  logic [31:0] r;
  logic        run;
  logic [2:0]  fld;
  integer      seed = 32'h87FD;
  int          err_total = 0;
  int          n_compared = 0;

  hcp_if link ();
  hcp_device hcp_device_inst (.port(link), .clk, .rstn, .ce, .master_rst_n, .interface_select,
    .serial_id_straps, .video_active_in, .drs_field, .drs_field_valid, .active_video_flag,
    .field_number_out, .outputs_enabled);
  // quarter bit set to 8 cycles, twice the low limit of 4, so serial frames stay short
  hcp_host #(.SCL_QTR_CYC(8)) hcp_host_inst (.port(link), .clk, .rstn, .ce, .use_serial,
    .cmd_valid, .cmd_ready, .cmd_read, .cmd_sel, .cmd_data, .rsp_valid, .rsp_data);
  hcp_checker hcp_checker_inst (.link_clk(link.link_clk), .rstn, .cs_n(link.cs_n), .rw_n(link.rw_n),
    .host_o(link.host_o), .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe),
    .host_data_bus(link.host_data_bus), .sda_dev_oe(link.sda_dev_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up;
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic op(input logic rd, input logic [1:0] sel, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_sel   <= sel;
    cmd_data  <= d;
    do @(negedge clk); while (cmd_ready !== 1'b1 && n++ < 9000);
    @(posedge clk);
    cmd_valid <= 1'b0;
    if (rd) begin
      do @(negedge clk); while (rsp_valid !== 1'b1 && n++ < 9000);
      q = rsp_data;
    end
    if (n >= 9000) err_total++;
  endtask

  task automatic wr(input logic [1:0] ps, input logic [7:0] ad, input logic [7:0] d);
    op(1'b0, ps, ad);
    op(1'b0, ps + 2'h1, d);
  endtask

  task automatic rd(input logic [1:0] ps, input logic [7:0] ad);
    op(1'b0, ps, ad);
    op(1'b1, ps + 2'h1, 8'h00);
  endtask

  // let the last transfer finish and the decoder's synchronisers settle
  task automatic idle;
    int n;
    n = 0;
    do @(negedge clk); while (cmd_ready !== 1'b1 && n++ < 9000);
    repeat (12) @(negedge clk);
  endtask

  task automatic mode(input logic s, input logic p);
    idle;
    @(posedge clk);
    use_serial       <= s;
    interface_select <= p;
    idle;
  endtask

  task automatic vid;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      @(posedge clk);
      video_active_in <= r[0];
      drs_field       <= r[3:1];
      drs_field_valid <= r[4] | (i == 0);
      if (r[4] | (i == 0)) fld = r[3:1];
      @(posedge clk);
      drs_field_valid <= 1'b0;
      repeat (3) @(negedge clk);
      chk("active_video_flag", {7'h0, r[0] & run}, {7'h0, active_video_flag});
      chk("field_number_out", {5'h0, run ? fld : 3'h0}, {5'h0, field_number_out});
    end
  endtask

  initial begin
    #1_600_000;
    err_total++;
    wrap_up;
  end

  initial begin
    rstn             = 1'b0;
    ce               = 1'b1;
    master_rst_n     = 1'b0;
    interface_select = 1'b1;
    serial_id_straps = 3'h2;
    video_active_in  = 1'b0;
    drs_field        = 3'h0;
    drs_field_valid  = 1'b0;
    use_serial       = 1'b0;
    cmd_valid        = 1'b0;
    cmd_read         = 1'b0;
    cmd_sel          = 2'h0;
    cmd_data         = 8'h00;
    run              = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    master_rst_n <= 1'b1;
    idle;
    chk("outputs_enabled", 8'h00, {7'h0, outputs_enabled});
    vid;
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      a = (i == 0 || r[5:0] == 6'h00) ? 8'h3F : {2'h0, r[5:0]};
      t = (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : r[23:16];
      regs[a] = r[15:8];
      lut[t] = r[31:24];
      wr(`HCP_SEL_REG_PTR, a, regs[a]);
      wr(`HCP_SEL_LUT_PTR, t, lut[t]);
      rd(`HCP_SEL_REG_PTR, a);
      chk("reg_data", regs[a], q);
      rd(`HCP_SEL_LUT_PTR, t);
      chk("lut_data", lut[t], q);
    end
    mode(1'b0, 1'b0);
    wr(`HCP_SEL_REG_PTR, a, ~regs[a]);
    rd(`HCP_SEL_REG_PTR, a);
    chk("released_bus", 8'hFF, q);
    mode(1'b1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      a = {2'h0, r[5:0] | 6'h01};
      regs[a] = r[15:8];
      wr(`HCP_SEL_REG_PTR, a, regs[a]);
      rd(`HCP_SEL_REG_PTR, a);
      chk("serial_data", regs[a], q);
    end
    @(posedge clk);
    serial_id_straps <= 3'h3;
    idle;
    wr(`HCP_SEL_REG_PTR, a, ~regs[a]);
    rd(`HCP_SEL_REG_PTR, a);
    chk("serial_data", 8'hFF, q);
    @(posedge clk);
    serial_id_straps <= 3'h2;
    mode(1'b0, 1'b1);
    rd(`HCP_SEL_REG_PTR, a);
    chk("reg_data", regs[a], q);
    wr(`HCP_SEL_REG_PTR, 8'h00, 8'h80);
    idle;
    run = 1'b1;
    chk("outputs_enabled", 8'h01, {7'h0, outputs_enabled});
    vid;
    @(posedge clk);
    master_rst_n <= 1'b0;
    repeat (20) @(negedge clk);
    run = 1'b0;
    chk("outputs_enabled", 8'h00, {7'h0, outputs_enabled});
    vid;
    @(posedge clk);
    master_rst_n <= 1'b1;
    idle;
    rd(`HCP_SEL_REG_PTR, 8'h00);
    chk("ctrl_reg", 8'h00, q);
    wr(`HCP_SEL_REG_PTR, 8'h00, 8'h40);
    idle;
    chk("outputs_enabled", 8'h00, {7'h0, outputs_enabled});
    @(posedge clk);
    master_rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    master_rst_n <= 1'b1;
    repeat (6) @(negedge clk);
    run = 1'b1;
    chk("outputs_enabled", 8'h01, {7'h0, outputs_enabled});
    rd(`HCP_SEL_REG_PTR, 8'h00);
    chk("ctrl_reg", 8'h40, q);
    vid;
    // enable low must freeze the flag although the video input drops
    @(posedge clk);
    video_active_in <= 1'b1;
    repeat (3) @(negedge clk);
    chk("active_video_flag", 8'h01, {7'h0, active_video_flag});
    @(posedge clk);
    ce              <= 1'b0;
    video_active_in <= 1'b0;
    repeat (4) @(negedge clk);
    chk("ce_freeze", 8'h01, {7'h0, active_video_flag});
    @(posedge clk);
    ce <= 1'b1;
    repeat (3) @(negedge clk);
    chk("active_video_flag", 8'h00, {7'h0, active_video_flag});
    wrap_up;
  end
endmodule // host_control_port_and_reset_tb
